/* File: core/jksr_top.sv */
`timescale 1ns/100ps
module jksr_top (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Control pins
	input wire logic master_clear_n,
	input wire logic register_clock,
	input wire logic shift_not_load,
	// Serial pair
	input wire logic ser_j,
	input wire logic ser_k_n,
	// Parallel data
	input wire jksr_pkg::jksr_word_t par_data,
	// Stage outputs
	output logic stage0_out,
	output logic stage1_out,
	output logic stage2_out,
	output logic stage3_out,
	output logic stage3_out_n
);
	import jksr_pkg::*;

	// Synchronised pin bundle
	jksr_pin_if sy ();
	// Stage registers
	jksr_word_t stage_q, stage_d;
	// Inverted last stage register
	logic inv_q, inv_d;
	// First stage next value in shift mode
	logic first_d;

	// Pin synchroniser
	jksr_pin_sync u_sync (
		.mclk(mclk),
		.rst(rst),
		.master_clear_n(master_clear_n),
		.register_clock(register_clock),
		.shift_not_load(shift_not_load),
		.ser_j(ser_j),
		.ser_k_n(ser_k_n),
		.par_data(par_data),
		.sy(sy)
	);

	// First stage behaviour from the serial pair
	always_comb begin
		case ({sy.ser_j, sy.ser_k_n})
			JKSR_JK_HOLD: first_d = stage_q[JKSR_FIRST];
			JKSR_JK_LOW: first_d = 1'h0;
			JKSR_JK_HIGH: first_d = 1'h1;
			JKSR_JK_TOGGLE: first_d = ~stage_q[JKSR_FIRST];
			default: first_d = stage_q[JKSR_FIRST];
		endcase
	end

	// Stage next values
	always_comb begin
		stage_d = stage_q;
		if (!sy.clr_n) begin
			// Clear overrides clock, mode and data
			stage_d = JKSR_STAGE_RST;
		end else if (sy.clk_rise) begin
			if (!sy.shift_mode) begin
				// Parallel load, serial pair unused
				stage_d = sy.par;
			end else begin
				// Shift toward last stage
				stage_d = {stage_q[JKSR_LAST-1:JKSR_FIRST], first_d};
			end
		end
		// Complement tracks the new last stage
		inv_d = ~stage_d[JKSR_LAST];
	end

	// Stage registers
	always_ff @(posedge mclk) begin
		if (rst) begin
			stage_q <= JKSR_STAGE_RST;
			inv_q <= JKSR_INV_RST;
		end else begin
			stage_q <= stage_d;
			inv_q <= inv_d;
		end
	end

	// Outputs straight from flip-flops
	assign stage0_out = stage_q[0];
	assign stage1_out = stage_q[1];
	assign stage2_out = stage_q[2];
	assign stage3_out = stage_q[JKSR_LAST];
	assign stage3_out_n = inv_q;

	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	// Qualified edge sequences
	sequence s_rise_load;
		sy.clr_n && sy.clk_rise && !sy.shift_mode;
	endsequence
	sequence s_rise_shift;
		sy.clr_n && sy.clk_rise && sy.shift_mode;
	endsequence
	// Register clock pin low once, then high for two samples
	sequence s_pin_rise;
		!register_clock ##1 register_clock [*2];
	endsequence

	// Synchronised clear empties the stages next cycle
	property p_clear;
		!sy.clr_n |=> (stage_q == JKSR_STAGE_RST) && inv_q;
	endproperty
	a_clear: assert property (p_clear) else $error("clear did not empty stages");

	// Clear pin held three cycles reaches the stages
	property p_pin_clear;
		!master_clear_n [*3] |=> (stage_q == JKSR_STAGE_RST) && inv_q;
	endproperty
	a_pin_clear: assert property (p_pin_clear) else $error("clear pin not seen in time");

	// Clear beats a coincident clock rise
	property p_clr_wins;
		!sy.clr_n && sy.clk_rise |=> (stage_q == JKSR_STAGE_RST) && inv_q;
	endproperty
	a_clr_wins: assert property (p_clr_wins) else $error("clock rise beat clear");

	// No rise, no movement
	property p_no_edge;
		sy.clr_n && !sy.clk_rise |=> $stable(stage_q) && $stable(inv_q);
	endproperty
	a_no_edge: assert property (p_no_edge) else $error("stages moved with no rise");

	// Pin rise reaches the core after the synchroniser
	property p_pin_rise;
		s_pin_rise |=> sy.clk_rise;
	endproperty
	a_pin_rise: assert property (p_pin_rise) else $error("clock rise not detected");

	// Steady low clock pin never yields a rise
	property p_clk_low;
		!register_clock [*3] |-> !sy.clk_rise;
	endproperty
	a_clk_low: assert property (p_clk_low) else $error("rise seen on low clock");

	// Steady high clock pin never yields a rise
	property p_clk_high;
		register_clock [*4] |-> !sy.clk_rise;
	endproperty
	a_clk_high: assert property (p_clk_high) else $error("rise seen on high clock");

	// One capture per rise
	property p_rise_once;
		sy.clk_rise |=> !sy.clk_rise;
	endproperty
	a_rise_once: assert property (p_rise_once) else $error("rise pulse too long");

	// Parallel load copies the data word
	property p_load;
		s_rise_load |=> stage_q == $past(sy.par);
	endproperty
	a_load: assert property (p_load) else $error("parallel load wrong");

	// Complement follows a load
	property p_load_inv;
		s_rise_load |=> inv_q == !$past(sy.par[JKSR_LAST]);
	endproperty
	a_load_inv: assert property (p_load_inv) else $error("complement wrong after load");

	// Stages move one onward
	property p_shift;
		s_rise_shift |=> stage_q[3:1] == $past(stage_q[2:0]);
	endproperty
	a_shift: assert property (p_shift) else $error("shift wrong");

	// Complement follows a shift
	property p_shift_inv;
		s_rise_shift |=> inv_q == !$past(stage_q[JKSR_LAST-1]);
	endproperty
	a_shift_inv: assert property (p_shift_inv) else $error("complement wrong after shift");

	// Hold code keeps the first stage
	property p_hold;
		s_rise_shift ##0 (!sy.ser_j && sy.ser_k_n) |=> $stable(stage_q[0]);
	endproperty
	a_hold: assert property (p_hold) else $error("first stage not held");

	// Low code clears the first stage
	property p_low;
		s_rise_shift ##0 (!sy.ser_j && !sy.ser_k_n) |=> !stage_q[0];
	endproperty
	a_low: assert property (p_low) else $error("first stage not low");

	// High code sets the first stage
	property p_high;
		s_rise_shift ##0 (sy.ser_j && sy.ser_k_n) |=> stage_q[0];
	endproperty
	a_high: assert property (p_high) else $error("first stage not high");

	// Toggle code flips the first stage
	property p_toggle;
		s_rise_shift ##0 (sy.ser_j && !sy.ser_k_n) |=> stage_q[0] != $past(stage_q[0]);
	endproperty
	a_toggle: assert property (p_toggle) else $error("first stage not toggled");

	// Complement output always opposes the last stage
	property p_inv;
		stage3_out_n == !stage3_out;
	endproperty
	a_inv: assert property (p_inv) else $error("inverted output mismatch");
endmodule

/* File: core/jksr_pkg.sv */
package jksr_pkg;
	// Number of register stages
	localparam int unsigned JKSR_STAGES = 4;
	// Flip-flops in each pin synchroniser
	localparam int unsigned JKSR_SYNC_DEPTH = 2;
	// Stage value after clear or reset
	localparam logic [JKSR_STAGES-1:0] JKSR_STAGE_RST = 4'h0;
	// Inverted last stage after clear or reset
	localparam logic JKSR_INV_RST = 1'h1;
	// Stage positions
	localparam int unsigned JKSR_FIRST = 0;
	localparam int unsigned JKSR_LAST = 3;
	// Serial pair codes {true, inverted}
	localparam logic [1:0] JKSR_JK_HOLD = 2'h1;
	localparam logic [1:0] JKSR_JK_LOW = 2'h0;
	localparam logic [1:0] JKSR_JK_HIGH = 2'h3;
	localparam logic [1:0] JKSR_JK_TOGGLE = 2'h2;
	// Synchroniser reset values
	localparam logic JKSR_SYNC_RST_HI = 1'h1;
	localparam logic JKSR_SYNC_RST_LO = 1'h0;
	// Pin vector type
	typedef logic [JKSR_STAGES-1:0] jksr_word_t;
endpackage

/* File: core/jksr_pin_if.sv */
`timescale 1ns/100ps
interface jksr_pin_if;
	import jksr_pkg::*;
	// Synchronised clear, low active
	logic clr_n;
	// One-cycle pulse on register clock rise
	logic clk_rise;
	// High selects shifting
	logic shift_mode;
	// Serial pair
	logic ser_j;
	logic ser_k_n;
	// Parallel data
	jksr_word_t par;
	// Synchroniser drives
	modport syn (output clr_n, output clk_rise, output shift_mode, output ser_j,
		output ser_k_n, output par);
	// Register core reads
	modport core (input clr_n, input clk_rise, input shift_mode, input ser_j,
		input ser_k_n, input par);
endinterface

/* File: core/jksr_pin_sync.sv */
`timescale 1ns/100ps
module jksr_pin_sync (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Raw pins
	input wire logic master_clear_n,
	input wire logic register_clock,
	input wire logic shift_not_load,
	input wire logic ser_j,
	input wire logic ser_k_n,
	input wire jksr_pkg::jksr_word_t par_data,
	// Synchronised side
	jksr_pin_if.syn sy
);
	import jksr_pkg::*;

	// Bundle of every pin
	localparam int unsigned NPIN = JKSR_STAGES + 5;
	// Reset value per pin: clear and register clock high, others low
	// A high clock history means an idle-high clock pin gives no false rise after reset
	localparam logic [NPIN-1:0] PIN_RST = {{(NPIN-2){JKSR_SYNC_RST_LO}}, JKSR_SYNC_RST_HI,
		JKSR_SYNC_RST_HI};
	logic [NPIN-1:0] raw;
	logic [NPIN-1:0] s1_q, s1_d;
	logic [NPIN-1:0] s2_q, s2_d;
	// Last seen level of register clock
	logic clk_hist_q, clk_hist_d;

	// Gather pins, clear at bit 0, clock at bit 1
	assign raw = {par_data, ser_k_n, ser_j, shift_not_load, register_clock, master_clear_n};

	// Two-stage synchroniser per pin
	genvar g;
	generate
		for (g = 0; g < NPIN; g++) begin : g_sync
			// Next values
			always_comb begin
				s1_d[g] = raw[g];
				s2_d[g] = s1_q[g];
			end
			// Registers
			always_ff @(posedge mclk) begin
				if (rst) begin
					s1_q[g] <= PIN_RST[g];
					s2_q[g] <= PIN_RST[g];
				end else begin
					s1_q[g] <= s1_d[g];
					s2_q[g] <= s2_d[g];
				end
			end
		end
	endgenerate

	// Edge history next value, reads second stage only
	always_comb begin
		clk_hist_d = s2_q[1];
	end

	// Edge history register
	always_ff @(posedge mclk) begin
		if (rst) begin
			clk_hist_q <= JKSR_SYNC_RST_HI;
		end else begin
			clk_hist_q <= clk_hist_d;
		end
	end

	// Outputs toward the core
	assign sy.clr_n = s2_q[0];
	assign sy.clk_rise = s2_q[1] & ~clk_hist_q;
	assign sy.shift_mode = s2_q[2];
	assign sy.ser_j = s2_q[3];
	assign sy.ser_k_n = s2_q[4];
	assign sy.par = s2_q[NPIN-1:5];
endmodule

/* File: verif/jksr_feed.sv */
`timescale 1ns/100ps
module jksr_feed (
	// Wiring select
	input wire logic fb_en,
	// Serial pair from the bench
	input wire logic bench_j,
	input wire logic bench_k_n,
	// Last stage taps
	input wire logic stage3_out,
	input wire logic stage3_out_n,
	// Serial pair to the register
	output logic ser_j,
	output logic ser_k_n
);
	// Counter wiring crosses the taps, so the first stage toggles until stage three sets
	always_comb begin
		ser_j = fb_en ? stage3_out_n : bench_j;
		ser_k_n = fb_en ? stage3_out : bench_k_n;
	end
endmodule

/* File: verif/jksr_top_bench.sv */
`timescale 1ns/100ps
module jksr_top_bench;
	import jksr_pkg::*;
	// Clock, reset and pins
	logic mclk = 0, rst = 1, clr_n = 1, rc = 0, sl = 0, j = 0, kn = 1, fb = 0;
	logic sj, skn, s0, s1, s2, s3, s3n;
	jksr_word_t par = 4'h0;
	// Expected stage word
	jksr_word_t exp_q = 4'h0;
	logic [1:0] codes [4] = '{JKSR_JK_TOGGLE, JKSR_JK_HOLD, JKSR_JK_LOW, JKSR_JK_HIGH};
	int fails = 0, checked = 0;
	// Clock of 100 ns
	initial begin
		forever #50 mclk = ~mclk;
	end
	// Serial pair wiring
	jksr_feed i_feed (.fb_en(fb), .bench_j(j), .bench_k_n(kn), .stage3_out(s3),
		.stage3_out_n(s3n), .ser_j(sj), .ser_k_n(skn));
	jksr_top i_dut (.mclk(mclk), .rst(rst), .master_clear_n(clr_n), .register_clock(rc),
		.shift_not_load(sl), .ser_j(sj), .ser_k_n(skn), .par_data(par), .stage0_out(s0),
		.stage1_out(s1), .stage2_out(s2), .stage3_out(s3), .stage3_out_n(s3n));
	// Compare all five outputs against a stage word
	task automatic chk(input jksr_word_t e);
		checked++;
		if ({s3n, s3, s2, s1, s0} !== {~e[3], e}) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, {s3n, s3, s2, s1, s0}, {~e[3], e});
		end
	endtask
	// Register clock high three cycles, then low three
	task automatic pulse();
		@(negedge mclk);
		rc = 1;
		repeat (3) @(negedge mclk);
		rc = 0;
		repeat (3) @(negedge mclk);
	endtask
	// Set pins, predict the next word, clock once
	task automatic step(input logic m, input logic [1:0] jk, input jksr_word_t d);
		logic f;
		sl = m;
		{j, kn} = jk;
		par = d;
		if (fb)
			jk = {~exp_q[3], exp_q[3]};
		case (jk)
			JKSR_JK_HOLD: f = exp_q[0];
			JKSR_JK_LOW: f = 1'h0;
			JKSR_JK_HIGH: f = 1'h1;
			default: f = ~exp_q[0];
		endcase
		exp_q = m ? {exp_q[2:0], f} : d;
		pulse();
	endtask
	// Parallel loads with a busy serial pair
	task automatic t_load();
		step(1'h0, JKSR_JK_TOGGLE, 4'hA);
		chk(exp_q);
		step(1'h0, JKSR_JK_HIGH, 4'h5);
		chk(exp_q);
		$display("test load done");
	endtask
	// Every serial code twice while shifting
	task automatic t_shift();
		for (int i = 0; i < 8; i++) begin
			step(1'h1, codes[i % 4], 4'hF);
			chk(exp_q);
		end
		$display("test shift done");
	endtask
	// Pins move with no clock rise, clock held low and then held high
	task automatic t_hold();
		par = ~exp_q;
		sl = 1'h0;
		j = ~j;
		repeat (10) @(negedge mclk);
		chk(exp_q);
		rc = 1'h1;
		exp_q = par;
		repeat (4) @(negedge mclk);
		par = ~par;
		sl = 1'h1;
		j = ~j;
		repeat (10) @(negedge mclk);
		chk(exp_q);
		rc = 1'h0;
		sl = 1'h0;
		repeat (3) @(negedge mclk);
		$display("test hold done");
	endtask
	// Clear with no clock, then a load attempt while cleared
	task automatic t_clear();
		clr_n = 1'h0;
		repeat (4) @(negedge mclk);
		exp_q = 4'h0;
		chk(exp_q);
		par = 4'hF;
		pulse();
		chk(exp_q);
		clr_n = 1'h1;
		repeat (3) @(negedge mclk);
		$display("test clear done");
	endtask
	// Feedback counter from cleared state returns to zero after fifteen shifts
	task automatic t_lfsr();
		fb = 1'h1;
		for (int i = 0; i < 15; i++) begin
			step(1'h1, JKSR_JK_LOW, 4'h0);
			chk(exp_q);
		end
		chk(4'h0);
		// All ones locks up under feedback until a clear
		step(1'h0, JKSR_JK_LOW, 4'hF);
		step(1'h1, JKSR_JK_LOW, 4'h0);
		chk(4'hF);
		clr_n = 1'h0;
		repeat (4) @(negedge mclk);
		clr_n = 1'h1;
		repeat (3) @(negedge mclk);
		exp_q = 4'h0;
		chk(exp_q);
		fb = 1'h0;
		$display("test counter done");
	endtask
	// Counts and verdict
	task automatic give_verdict();
		$display("checked=%0d fails=%0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Hang guard
	initial begin
		#2000000;
		fails++;
		give_verdict();
	end
	// Main sequence
	initial begin
		repeat (20) @(negedge mclk);
		rst = 0;
		repeat (3) @(negedge mclk);
		chk(JKSR_STAGE_RST);
		t_load();
		t_shift();
		t_hold();
		t_clear();
		t_lfsr();
		give_verdict();
	end
endmodule
